// [verilog/dcp_regs.sv]
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
// Eight-channel count and page register file
module dcp_regs
  import dcp_pkg::*;
(
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      reset,
  // Register port
  input  dcp_pkg::dcp_bus_s              bus,
  output logic [7:0]                     rdata,
  // Transfer engine side
  input  dcp_pkg::dcp_xfer_s             xfer,
  output logic [31:0]                    cur_addr_high,
  output logic [dcp_pkg::NUM_CHAN-1:0]   terminal_count_event,
  output logic [dcp_pkg::NUM_CHAN-1:0]   word_mode
);
  import dcp_pkg::*;

  // Whole-block register state
  typedef struct packed {
    logic                 byte_ptr;
    logic [NUM_CHAN-1:0]  autoinit;
    logic [NUM_CHAN-1:0]  sg_mode;
    logic [NUM_CHAN-1:0]  tc_sticky;
    logic [CHAN_W-1:0]    cnt_sel;
    logic [7:0]           rdata;
    logic [31:0]          page_out;
    logic [NUM_CHAN-1:0]  tc_out;
  } dcp_top_s;

  dcp_top_s  t_r, t_nxt;
  dcp_chan_s ch_st [NUM_CHAN];
  logic [NUM_CHAN-1:0] tc_p;
  logic [NUM_CHAN-1:0] wr_cnt, wr_lo, wr_hi;

  // Channel window decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input int c,
                               input logic [2:0] ofs);
    hit = (a == (ADDR_W'(c) * CHAN_STRIDE) + {{(ADDR_W-3){1'b0}}, ofs});
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_CHAN; g++) begin : g_ch
      assign wr_cnt[g] = bus.wr && hit(bus.addr, g, OFS_COUNT);
      assign wr_lo[g]  = bus.wr && hit(bus.addr, g, OFS_LOW_PAGE);
      assign wr_hi[g]  = bus.wr && hit(bus.addr, g, OFS_HIGH_PAGE);
      dcp_chan u_chan (
        .clk          (clk),
        .reset        (reset),
        .wr_count     (wr_cnt[g]),
        .count_high   (t_r.byte_ptr),
        .wr_low_page  (wr_lo[g]),
        .wr_high_page (wr_hi[g]),
        .wdata        (bus.wdata),
        .autoinit     (t_r.autoinit[g]),
        .sg_mode      (t_r.sg_mode[g]),
        .step         (xfer.step && xfer.chan == CHAN_W'(g)),
        .addr_carry   (xfer.addr_carry),
        .addr_borrow  (xfer.addr_borrow),
        .state        (ch_st[g]),
        .tc_pulse     (tc_p[g])
      );
    end
  endgenerate

  always_comb begin
    for (int i = 0; i < NUM_CHAN; i++) begin
      word_mode[i] = (i >= NUM_CHAN / 2);
    end
  end

  assign rdata                = t_r.rdata;
  assign cur_addr_high        = t_r.page_out;
  assign terminal_count_event = t_r.tc_out;

  // Next block state
  always_comb begin
    t_nxt          = t_r;
    t_nxt.rdata    = BYTE_ZERO;
    t_nxt.tc_out   = tc_p;
    t_nxt.page_out = {ch_st[xfer.chan].cur_high_page, ch_st[xfer.chan].cur_low_page, 16'h0000};
    if (|wr_cnt) begin
      t_nxt.byte_ptr = !t_r.byte_ptr;
    end
    if (bus.wr) begin
      if (bus.addr == ADDR_BP_CLEAR) begin
        t_nxt.byte_ptr = 1'b0;
      end else if (bus.addr == ADDR_AUTOINIT) begin
        t_nxt.autoinit = bus.wdata;
      end else if (bus.addr == ADDR_SG_MODE) begin
        t_nxt.sg_mode = bus.wdata;
      end else if (bus.addr == ADDR_TC_STATUS) begin
        t_nxt.tc_sticky = t_r.tc_sticky & ~bus.wdata;
      end else if (bus.addr == ADDR_CUR_COUNT) begin
        t_nxt.cnt_sel = bus.wdata[CHAN_W-1:0];
      end
    end
    // Hardware set wins over clear
    t_nxt.tc_sticky = t_nxt.tc_sticky | tc_p;
    if (bus.rd) begin
      if (bus.addr == ADDR_AUTOINIT) begin
        t_nxt.rdata = t_r.autoinit;
      end else if (bus.addr == ADDR_SG_MODE) begin
        t_nxt.rdata = t_r.sg_mode;
      end else if (bus.addr == ADDR_TC_STATUS) begin
        t_nxt.rdata = t_r.tc_sticky;
      end else if (bus.addr == ADDR_CUR_COUNT) begin
        t_nxt.rdata = t_r.byte_ptr ? ch_st[t_r.cnt_sel].cur_count[15:8]
                                   : ch_st[t_r.cnt_sel].cur_count[7:0];
        t_nxt.byte_ptr = !t_r.byte_ptr;
      end else begin
        for (int i = 0; i < NUM_CHAN; i++) begin
          if (hit(bus.addr, i, OFS_LOW_PAGE)) begin
            t_nxt.rdata = ch_st[i].cur_low_page;
          end else if (hit(bus.addr, i, OFS_HIGH_PAGE)) begin
            t_nxt.rdata = ch_st[i].cur_high_page;
          end
        end
      end
    end
  end

  // Block registers
  always_ff @(posedge clk) begin
    if (reset) begin
      t_r <= '0;
    end else begin
      t_r <= t_nxt;
    end
  end
endmodule // dcp_regs

// [verilog/dcp_pkg.sv]
// Notes on behaviour
// - Each channel has 16-bit write-only base count
// - First byte low half, second byte high
// - Count offset shared; writes seed current count
// - Scatter/gather keeps reserve count in base
// - Channels 0-3 count bytes minus one
// - Channels 4-7 count 16-bit words
// - Decrement, wrap raises terminal count, autoinit reloads
// - Current low page gives address bits 23-16
// - Scatter/gather address carry/borrow adjusts low page
// - Plain transfers need no low page carry
// - Low page write loads current and base
// - Autoinit terminal count restores low page
// - Base low page holds reserve buffer address
// - Current high page gives address bits 31-24
// - Scatter/gather low page carry adjusts high page
// - Plain transfers need no high page carry
// - High page write loads current and base
// - Low page write clears current high page
// - Autoinit restores high page; base holds reserve
// - Eight identical channels, each own address
package dcp_pkg;
  localparam int NUM_CHAN = 8;
  localparam int CHAN_W   = 3;
  localparam int ADDR_W   = 8;
  // Register index within a channel's 8-slot window
  localparam logic [2:0] OFS_COUNT     = 3'h1;
  localparam logic [2:0] OFS_HIGH_PAGE = 3'h6;
  localparam logic [2:0] OFS_LOW_PAGE  = 3'h7;
  // Window base of channel n is n times the stride
  localparam logic [ADDR_W-1:0] CHAN_STRIDE = 8'h08;
  // Extra control registers above the channel windows
  localparam logic [ADDR_W-1:0] ADDR_BP_CLEAR   = 8'h40;
  localparam logic [ADDR_W-1:0] ADDR_AUTOINIT   = 8'h41;
  localparam logic [ADDR_W-1:0] ADDR_SG_MODE    = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_TC_STATUS  = 8'h43;
  localparam logic [ADDR_W-1:0] ADDR_CUR_COUNT  = 8'h48;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] COUNT_WRAP  = 16'hffff;
  localparam logic [7:0]  PAGE_RESET  = 8'h00;
  localparam logic [7:0]  PAGE_MAX    = 8'hff;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;

  // Register port request
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0]        wdata;
    logic              wr;
    logic              rd;
  } dcp_bus_s;

  // One transfer step from the engine
  typedef struct packed {
    logic [CHAN_W-1:0] chan;
    logic              step;
    logic              addr_carry;
    logic              addr_borrow;
  } dcp_xfer_s;

  // State of one channel
  typedef struct packed {
    logic [15:0] base_count;
    logic [15:0] cur_count;
    logic [7:0]  cur_low_page;
    logic [7:0]  base_low_page;
    logic [7:0]  cur_high_page;
    logic [7:0]  base_high_page;
  } dcp_chan_s;
endpackage

// [verilog/dcp_chan.sv]
`timescale 1ns/1ps
// One channel's count and page registers
module dcp_chan
  import dcp_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      reset,
  // Software writes, already decoded to this channel
  input  wire logic      wr_count,
  input  wire logic      count_high,
  input  wire logic      wr_low_page,
  input  wire logic      wr_high_page,
  input  wire logic [7:0] wdata,
  // Mode bits
  input  wire logic      autoinit,
  input  wire logic      sg_mode,
  // Transfer step
  input  wire logic      step,
  input  wire logic      addr_carry,
  input  wire logic      addr_borrow,
  // State and events
  output dcp_pkg::dcp_chan_s state,
  output logic           tc_pulse
);
  import dcp_pkg::*;

  dcp_chan_s st_r, st_nxt;
  logic      tc_r, tc_nxt;

  assign state    = st_r;
  assign tc_pulse = tc_r;

  // Next channel state
  always_comb begin
    st_nxt = st_r;
    tc_nxt = 1'b0;
    if (wr_count) begin
      if (count_high) begin
        st_nxt.base_count[15:8] = wdata;
        st_nxt.cur_count[15:8]  = wdata;
      end else begin
        st_nxt.base_count[7:0] = wdata;
        st_nxt.cur_count[7:0]  = wdata;
      end
    end else if (step) begin
      st_nxt.cur_count = st_r.cur_count - 16'h0001;
      if (st_r.cur_count == COUNT_RESET) begin
        tc_nxt = 1'b1;
        if (autoinit) begin
          st_nxt.cur_count = st_r.base_count;
        end
      end
    end
    if (step && sg_mode && !(autoinit && st_r.cur_count == COUNT_RESET)) begin
      if (addr_carry) begin
        st_nxt.cur_low_page = st_r.cur_low_page + 8'h01;
        if (st_r.cur_low_page == PAGE_MAX) begin
          st_nxt.cur_high_page = st_r.cur_high_page + 8'h01;
        end
      end else if (addr_borrow) begin
        st_nxt.cur_low_page = st_r.cur_low_page - 8'h01;
        if (st_r.cur_low_page == PAGE_RESET) begin
          st_nxt.cur_high_page = st_r.cur_high_page - 8'h01;
        end
      end
    end
    if (step && autoinit && st_r.cur_count == COUNT_RESET) begin
      st_nxt.cur_low_page  = st_r.base_low_page;
      st_nxt.cur_high_page = st_r.base_high_page;
    end
    if (wr_low_page) begin
      st_nxt.cur_low_page  = wdata;
      st_nxt.base_low_page = wdata;
      st_nxt.cur_high_page = PAGE_RESET;
    end
    if (wr_high_page) begin
      st_nxt.cur_high_page  = wdata;
      st_nxt.base_high_page = wdata;
    end
  end

  // State registers
  always_ff @(posedge clk) begin
    if (reset) begin
      st_r <= '{COUNT_RESET, COUNT_RESET, PAGE_RESET, PAGE_RESET, PAGE_RESET, PAGE_RESET};
      tc_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      tc_r <= tc_nxt;
    end
  end
endmodule // dcp_chan

// [test/dcp_props_properties.sv]
`timescale 1ns/1ps
// Port checks on the register file
module dcp_props
  import dcp_pkg::*;
(
  // Watched ports
  input wire logic                   clk,
  input wire logic                   reset,
  input dcp_pkg::dcp_bus_s           bus,
  input wire logic [7:0]             rdata,
  input dcp_pkg::dcp_xfer_s          xfer,
  input wire logic [31:0]            cur_addr_high,
  input wire logic [NUM_CHAN-1:0]    terminal_count_event,
  input wire logic [NUM_CHAN-1:0]    word_mode
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Page writes into a channel window with no step beside them
  wire cw   = bus.wr && bus.addr < ADDR_BP_CLEAR;
  wire lo_w = cw && bus.addr[2:0] == OFS_LOW_PAGE && !xfer.step;
  wire hi_w = cw && bus.addr[2:0] == OFS_HIGH_PAGE && !xfer.step;
  // Read-back and event timing
  word_cnt_a: assert property (word_mode == 8'hf0)
    else $error("word mode");
  cnt_wo_a: assert property (bus.rd && bus.addr < ADDR_BP_CLEAR &&
    bus.addr[2:0] == OFS_COUNT |=> rdata == 8'h00) else $error("count readable");
  lo_rb_a: assert property (lo_w ##1 bus.rd && bus.addr == $past(bus.addr)
    |=> rdata == $past(bus.wdata, 2)) else $error("low page");
  hi_rb_a: assert property (hi_w ##1 bus.rd && bus.addr == $past(bus.addr)
    |=> rdata == $past(bus.wdata, 2)) else $error("high page");
  hi_clr_a: assert property (lo_w ##1 bus.rd &&
    bus.addr == $past(bus.addr) - 8'h01 |=> rdata == 8'h00) else $error("high kept");
  addr_hi_a: assert property (hi_w && xfer.chan == bus.addr[5:3] ##1
    !bus.wr && !xfer.step && $stable(xfer.chan)
    |=> cur_addr_high[31:24] == $past(bus.wdata, 2)) else $error("addr high");
  addr_lo_a: assert property (cur_addr_high[15:0] == 16'h0000)
    else $error("addr low");
  tc_time_a: assert property (|terminal_count_event |-> $past(xfer.step, 2) &&
    terminal_count_event == (8'h01 << $past(xfer.chan, 2))) else $error("tc");
endmodule // dcp_props

// [test/dcp_engine_model.sv]
`timescale 1ns/1ps
// Engine stand-in: bursts of steps, prompt or every other cycle
module dcp_engine_model
  import dcp_pkg::*;
(
  // Clock, reset and burst request
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic              go,
  input  wire logic [CHAN_W-1:0] chan,
  input  wire logic [3:0]        n,
  input  wire logic [1:0]        adj,
  input  wire logic              slow,
  // Step stream
  output dcp_pkg::dcp_xfer_s     xfer,
  output logic                   busy
);
  logic [3:0] left_r;
  logic       gap_r;
  wire        fire = busy && !gap_r;
  assign busy = left_r != 4'h0;
  // Count down the burst; carry or borrow rides on each step
  always_ff @(posedge clk) begin
    if (reset) begin
      left_r <= 4'h0;
      gap_r  <= 1'b0;
      xfer   <= '0;
    end else begin
      xfer.chan        <= chan;
      xfer.step        <= fire;
      xfer.addr_carry  <= fire && adj[0];
      xfer.addr_borrow <= fire && adj[1];
      gap_r            <= fire && slow;
      if (go) begin
        left_r <= n;
      end else if (fire) begin
        left_r <= left_r - 4'h1;
      end
    end
  end
endmodule // dcp_engine_model

// [test/dcp_regs_test.sv]
`timescale 1ns/1ps
// Self-checking bench for the register file
module dcp_regs_test;
  import dcp_pkg::*;
  logic              clk = 1'b0;
  logic              reset, go, slow, busy, rd_pend = 1'b0;
  dcp_bus_s          bus;
  dcp_xfer_s         xfer;
  logic [7:0]        rdata, tce, wm, c1, c2, lo [8], hi [8], rd_q [$], tc_q [$];
  logic [31:0]       cah;
  logic [CHAN_W-1:0] ch;
  logic [3:0]        nst;
  logic [1:0]        adj;
  int                n_errors = 0, checks = 0, i, k, seed;

  dcp_regs DUT (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata), .xfer(xfer),
    .cur_addr_high(cah), .terminal_count_event(tce), .word_mode(wm));
  dcp_engine_model eng (.clk(clk), .reset(reset), .go(go), .chan(ch), .n(nst),
    .adj(adj), .slow(slow), .xfer(xfer), .busy(busy));

  always #2.5 clk = ~clk;

  task automatic check(logic [7:0] got, logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic finish_test();
    if (rd_q.size() != 0 || tc_q.size() != 0) n_errors++;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Bus cycles: one strobe cycle each, back to back
  task automatic wr(logic [7:0] a, logic [7:0] d);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    rd_q.push_back(e);
    @(posedge clk);
  endtask
  // Burst of steps on channel 5, bounded wait for the engine
  task automatic burst(logic [3:0] n, logic [1:0] a, logic s);
    bus <= '0;
    ch   <= 3'h5;
    nst  <= n;
    adj  <= a;
    slow <= s;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (2) @(posedge clk);
    for (k = 0; k < 40 && busy; k++) @(posedge clk);
    if (busy) begin
      n_errors++;
      finish_test();
    end
    repeat (4) @(posedge clk);
  endtask

  // Oldest note against each read answer and event
  always @(posedge clk) begin
    if (rd_pend) check(rdata, rd_q.pop_front());
    if (!reset && tce !== 8'h00) begin
      check(tce, tc_q.size() != 0 ? tc_q.pop_front() : 8'h00);
    end
    rd_pend <= bus.rd;
  end

  initial begin
    bus   = '0;
    go    = 1'b0;
    ch    = '0;
    nst   = '0;
    adj   = '0;
    slow  = 1'b0;
    reset = 1'b1;
    seed = $urandom(25);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    check(wm, 8'hf0);
    // Reset contents, count offset and an unmapped slot read as zero
    for (i = 0; i < 8; i++) begin
      rd(8'(8*i+7), 8'h00);
      rd(8'(8*i+1), 8'h00);
    end
    rd(8'h44, 8'h00);
    // Pages per channel, low before high, then read across all
    for (i = 0; i < 8; i++) begin
      ch <= 3'(i);
      lo[i] = 8'($urandom);
      hi[i] = 8'($urandom);
      wr(8'(8*i+7), lo[i]);
      rd(8'(8*i+7), lo[i]);
      wr(8'(8*i+6), hi[i]);
      rd(8'(8*i+6), hi[i]);
    end
    check(cah[23:16], lo[7]);
    for (i = 0; i < 8; i++) begin
      rd(8'(8*i+7), lo[i]);
      rd(8'(8*i+6), hi[i]);
      wr(8'(8*i+7), lo[i]);
      rd(8'(8*i+6), 8'h00);
    end
    // Count bytes pair low then high after a pointer clear
    c1 = 8'($urandom);
    c2 = 8'($urandom);
    wr(8'h40, 8'h00);
    wr(8'h19, c1);
    wr(8'h19, c2);
    wr(8'h48, 8'h03);
    wr(8'h40, 8'h00);
    rd(8'h48, c1);
    rd(8'h48, c2);
    // Scatter/gather carry, wrap with reload, then borrow; pages unshifted
    wr(8'h2f, 8'hff);
    wr(8'h2e, 8'h12);
    wr(8'h41, 8'h20);
    wr(8'h42, 8'h20);
    rd(8'h41, 8'h20);
    rd(8'h42, 8'h20);
    wr(8'h40, 8'h00);
    wr(8'h29, 8'h02);
    wr(8'h29, 8'h00);
    burst(4'd1, 2'b01, 1'b1);
    rd(8'h2f, 8'h00);
    rd(8'h2e, 8'h13);
    tc_q.push_back(8'h20);
    burst(4'd2, 2'b00, 1'b0);
    rd(8'h2f, 8'hff);
    rd(8'h2e, 8'h12);
    rd(8'h43, 8'h20);
    wr(8'h43, 8'h20);
    rd(8'h43, 8'h00);
    wr(8'h48, 8'h05);
    wr(8'h40, 8'h00);
    rd(8'h48, 8'h02);
    rd(8'h48, 8'h00);
    wr(8'h2f, 8'h00);
    wr(8'h2e, 8'h05);
    burst(4'd1, 2'b10, 1'b1);
    rd(8'h2f, 8'hff);
    rd(8'h2e, 8'h04);
    // Plain mode: a carry must leave both pages alone
    wr(8'h42, 8'h00);
    burst(4'd1, 2'b01, 1'b0);
    rd(8'h2f, 8'hff);
    rd(8'h2e, 8'h04);
    bus <= '0;
    repeat (3) @(posedge clk);
    finish_test();
  end
endmodule // dcp_regs_test

bind dcp_regs dcp_props chk (.clk(clk), .reset(reset), .bus(bus), .rdata(rdata),
  .xfer(xfer), .cur_addr_high(cur_addr_high),
  .terminal_count_event(terminal_count_event), .word_mode(word_mode));
